// >>> design/ext_page1_regs.sv
/*
  extended page one register bank with page select, reached over apb.
  assumes pins from the line side (fault, remote fault, packet pulses)
  are already on pclk except low_power_hold_input, which is synchronised.
*/
`timescale 1ns/10ps
module ext_page1_regs (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [1:0] port_id, // this port's number
  input wire logic soft_reset, // soft reset pulse
  input wire logic [1:0] lp_remote_fault, // link partner fault bits
  input wire logic far_end_fault, // 100 Mb fiber far-end fault pulse
  input wire logic good_pkt, // good crc copper packet pulse
  input wire logic low_power_hold_input, // low-power hold pin
  input wire logic [15:0] main_rdata, // main-space read data
  output logic main_wr, // main-space write strobe
  output logic main_rd, // main-space read strobe
  output logic [4:0] main_addr, // main-space register address
  output logic [15:0] main_wdata, // main-space write data
  output logic [1:0] tx_remote_fault, // remote fault code to send
  output logic allow_1g_link, // gigabit fiber link-up allowed
  output logic allow_100_link, // 100 Mb fiber link-up allowed
  output logic [3:0] led_ext_mode, // per-led extended mode
  output logic led_blink, // leds blink now
  output logic spare_pin_nine_flf, // spare pin is fast link failure
  output logic [1:0] xover_mode, // crossover selection
  output logic signal_detect_input_low // signal detect is active low
);
  logic [15:0] page_r;
  logic [1:0] txrf_r;
  logic allow_1g_r;
  logic allow_100_r;
  logic [1:0] lprf_r;
  logic fef_r;
  logic [3:0] ledx_r;
  logic blink_r;
  logic flf_r;
  logic [1:0] xover_r;
  logic sdpol_r;
  logic [31:0] prdata_r;
  logic [2:0] hold_sync_r;
  logic hold_r;
  logic blink_act_r;
  logic [15:0] crc_value;

  mgmt_if acc ();

  // apb: zero wait, so every access completes in its first access cycle
  wire access = psel & penable;
  assign acc.wr = access & pwrite;
  assign acc.rd = access & ~pwrite;
  assign acc.addr = paddr[ext_page1_pkg::ADDR_MSB:ext_page1_pkg::ADDR_LSB];
  assign acc.wdata = pwdata[15:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  wire mapped = (paddr[31:ext_page1_pkg::ADDR_MSB+1] == '0) &
                (paddr[1:0] == 2'h0);
  wire is_page = mapped & (acc.addr == ext_page1_pkg::REG_PAGE);
  wire upper = acc.addr >= ext_page1_pkg::UPPER_BASE;
  wire ext_sel = (page_r == ext_page1_pkg::PAGE_EXT1); // [RQ1]
  // low addresses never look at the page register
  wire to_ext = mapped & upper & ~is_page & ext_sel; // [RQ3] [RQ4]
  wire to_main = mapped & ~is_page & ~to_ext; // [RQ2] [RQ4]
  wire port_ok = (port_id <= ext_page1_pkg::PORT_MAX); // [RQ6]
  wire hit_fiber = to_ext & (acc.addr == ext_page1_pkg::REG_FIBER) & port_ok;
  wire hit_crc = to_ext & (acc.addr == ext_page1_pkg::REG_CRC);
  wire hit_ext = to_ext & (acc.addr == ext_page1_pkg::REG_EXTMODE);
  wire port0 = (port_id == ext_page1_pkg::PORT_ZERO);

  wire wr_page = acc.wr & is_page;
  wire wr_fiber = acc.wr & hit_fiber;
  wire wr_ext = acc.wr & hit_ext;
  wire rd_fiber = acc.rd & hit_fiber;
  wire rd_crc = acc.rd & hit_crc;

  assign main_wr = acc.wr & to_main;
  assign main_rd = acc.rd & to_main;
  assign main_addr = acc.addr;
  assign main_wdata = acc.wdata;

  good_crc_counter u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .good_pkt(good_pkt),
    .rd_clr(rd_crc),
    .value(crc_value)
  );

  wire [15:0] fiber_value = {txrf_r, lprf_r, 2'h0, allow_1g_r, allow_100_r,
                             1'b0, fef_r, 6'h00}; // [RQ8] [RQ11] [RQ20]
  wire [15:0] ext_value = {ledx_r, blink_r, 6'h00, flf_r, xover_r, 1'b0,
                           sdpol_r}; // [RQ20]

  // unmapped or reserved page-one addresses read zero
  wire [15:0] rd_mux = is_page ? page_r :
                       to_main ? main_rdata :
                       hit_fiber ? fiber_value :
                       hit_crc ? crc_value :
                       hit_ext ? ext_value : 16'h0000; // [RQ20] [RQ19]

  // page select: any written value is kept, only 0x0001 maps page one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= ext_page1_pkg::PAGE_MAIN; // [RQ5]
    end else if (wr_page) begin
      page_r <= acc.wdata; // [RQ1] [RQ2]
    end
  end

  // fiber media control; soft reset restores only the transmitted remote fault code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txrf_r <= ext_page1_pkg::TXRF_RST;
      allow_1g_r <= ext_page1_pkg::ALLOW_RST;
      allow_100_r <= ext_page1_pkg::ALLOW_RST;
    end else if (wr_fiber) begin
      txrf_r <= acc.wdata[ext_page1_pkg::TXRF_HI:ext_page1_pkg::TXRF_LO];
      allow_1g_r <= acc.wdata[ext_page1_pkg::ALLOW_1G_BIT]; // [RQ9]
      allow_100_r <= acc.wdata[ext_page1_pkg::ALLOW_100_BIT]; // [RQ10]
    end else if (soft_reset) begin
      txrf_r <= ext_page1_pkg::TXRF_RST; // [RQ7]
    end
  end

  // link partner fault is sampled so a read sees a stable value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lprf_r <= 2'h0;
    end else begin
      lprf_r <= lp_remote_fault; // [RQ8]
    end
  end

  // far-end fault: a new fault in the read cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fef_r <= 1'b0;
    end else begin
      fef_r <= far_end_fault | (fef_r & ~rd_fiber); // [RQ11]
    end
  end

  // extended mode control; fast link failure only takes on port zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ledx_r <= 4'h0;
      blink_r <= 1'b0;
      flf_r <= 1'b0;
      xover_r <= ext_page1_pkg::XOVER_AUTO;
      sdpol_r <= 1'b0;
    end else if (wr_ext) begin
      ledx_r <= acc.wdata[ext_page1_pkg::LEDX_HI:ext_page1_pkg::LEDX_LO];
      blink_r <= acc.wdata[ext_page1_pkg::BLINK_BIT]; // [RQ16]
      if (port0) begin
        flf_r <= acc.wdata[ext_page1_pkg::FLF_BIT]; // [RQ17]
      end
      xover_r <= acc.wdata[ext_page1_pkg::XOVER_HI:ext_page1_pkg::XOVER_LO];
      sdpol_r <= acc.wdata[ext_page1_pkg::SDPOL_BIT];
    end
  end

  // hold pin comes from outside; a change counts once stages two and three
  // agree, so a single glitch cannot trigger a blink
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_sync_r <= 3'h0;
      hold_r <= 1'b0;
      blink_act_r <= 1'b0;
    end else begin
      hold_sync_r <= {hold_sync_r[1:0], low_power_hold_input};
      if (hold_sync_r[2] == hold_sync_r[1]) begin
        hold_r <= hold_sync_r[2];
      end
      // blink starts at release if enabled, stops when hold reasserts
      if (hold_r && (hold_sync_r[2] == hold_sync_r[1]) && !hold_sync_r[2]) begin
        blink_act_r <= blink_r; // [RQ16]
      end else if (hold_r || !blink_r) begin
        blink_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (acc.rd) begin
      prdata_r <= {16'h0000, rd_mux};
    end
  end

  // read data is taken at the same edge, so drive the mux while reading
  assign prdata = acc.rd ? {16'h0000, rd_mux} : prdata_r;

  assign tx_remote_fault = port_ok ? txrf_r : 2'h0; // [RQ7] [RQ6]
  assign allow_1g_link = allow_1g_r & port_ok; // [RQ9]
  assign allow_100_link = allow_100_r & port_ok; // [RQ10]
  assign led_ext_mode = ledx_r; // [RQ15]
  assign led_blink = blink_act_r;
  assign spare_pin_nine_flf = flf_r; // [RQ17]
  // reserved code 01 falls back to automatic crossover
  assign xover_mode = (xover_r == ext_page1_pkg::XOVER_RSVD) ?
                      ext_page1_pkg::XOVER_AUTO : xover_r; // [RQ18]
  assign signal_detect_input_low = sdpol_r;
endmodule

// >>> design/ext_page1_pkg.sv
/*
  holds the register map, field positions, reset values and enumerations
  for the extended page one register bank.
  assumes a 32-bit apb slave, one 16-bit register per aligned word.
*/
// Notes on behaviour
// RQ1 - writing 0x0001 to page select routes upper addresses to page one
// RQ2 - writing zero to page select returns upper addresses to main space
// RQ3 - with page one selected, addresses 16 to 30 hit page-one registers
// RQ4 - addresses 0 to 15 reach the same registers under any page
// RQ5 - page select resets to zero
// RQ6 - fiber media control settings apply only to ports zero to three
// RQ7 - bits 15:14 hold the transmitted remote fault code, reset zero
// RQ8 - bits 13:12 report link partner remote fault bits, read only
// RQ9 - bit 9 allows gigabit fiber link-up, resets one, survives soft reset
// RQ10 - bit 8 allows 100 Mb/s fiber link-up, resets one
// RQ11 - bit 6 latches far-end fault and clears once read
// RQ12 - good-crc bit 15 flags a packet since last read, clears on read
// RQ13 - fourteen-bit good-crc counter modulo ten thousand, clears on read
// RQ14 - counter never saturates, wraps to zero after 9999
// RQ15 - bits 15:12 switch each led into extended mode, reset zero
// RQ16 - bit 11 selects led blink after low-power hold release
// RQ17 - bit 4 turns spare pin nine into fast link failure, port zero only
// RQ18 - bits 3:2 select auto, forced mdi or forced mdi-x crossover
// RQ19 - one read returns counter and flag together, then clears both
// RQ20 - reserved bits and addresses read zero and ignore writes
package ext_page1_pkg;
  localparam logic [4:0] REG_PAGE = 5'h1F;
  localparam logic [4:0] REG_FIBER = 5'h10;
  localparam logic [4:0] REG_CRC = 5'h12;
  localparam logic [4:0] REG_EXTMODE = 5'h13;
  localparam logic [4:0] UPPER_BASE = 5'h10;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 6;
  localparam int SOFT_RST_BIT = 15;
  // fiber media control fields
  localparam int TXRF_HI = 15;
  localparam int TXRF_LO = 14;
  localparam int LPRF_HI = 13;
  localparam int LPRF_LO = 12;
  localparam int ALLOW_1G_BIT = 9;
  localparam int ALLOW_100_BIT = 8;
  localparam int FEF_BIT = 6;
  localparam logic [1:0] TXRF_RST = 2'h0;
  localparam logic ALLOW_RST = 1'b1;
  // good crc register
  localparam int PKT_BIT = 15;
  localparam int CNT_W = 14;
  localparam logic [13:0] CNT_MAX = 14'h270F;
  localparam logic [13:0] CNT_ZERO = 14'h0000;
  // extended mode control fields
  localparam int LEDX_HI = 15;
  localparam int LEDX_LO = 12;
  localparam int BLINK_BIT = 11;
  localparam int FLF_BIT = 4;
  localparam int XOVER_HI = 3;
  localparam int XOVER_LO = 2;
  localparam int SDPOL_BIT = 0;
  localparam logic [1:0] PORT_ZERO = 2'h0;
  localparam logic [1:0] PORT_MAX = 2'h3;
  typedef enum logic [1:0] {
    XOVER_AUTO = 2'h0,
    XOVER_RSVD = 2'h1,
    XOVER_MDI = 2'h2,
    XOVER_MDIX = 2'h3
  } xover_e;
endpackage

// >>> design/mgmt_if.sv
/*
  carries one decoded register access from the apb front to the bank.
  assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface mgmt_if;
  logic wr;
  logic rd;
  logic [4:0] addr;
  logic [15:0] wdata;
  modport front (output wr, output rd, output addr, output wdata);
  modport bank (input wr, input rd, input addr, input wdata);
endinterface

// >>> design/good_crc_counter.sv
/*
  good-crc packet counter with packet-since-read flag.
  assumes good_pkt is a one-cycle pulse on pclk; rd_clr is the read strobe.
*/
`timescale 1ns/10ps
module good_crc_counter (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic good_pkt, // good crc packet pulse
  input wire logic rd_clr, // register read strobe
  output logic [15:0] value // current register value
);
  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;
  logic pkt_r;
  logic pkt_nxt;
  wire [13:0] cnt_inc = (cnt_r == ext_page1_pkg::CNT_MAX) ?
                        ext_page1_pkg::CNT_ZERO : cnt_r + 14'h0001; // [RQ14]
  // a packet in the read cycle is kept as the first count after the clear
  assign cnt_nxt = rd_clr ? (good_pkt ? 14'h0001 : ext_page1_pkg::CNT_ZERO)
                          : (good_pkt ? cnt_inc : cnt_r); // [RQ13] [RQ19]
  assign pkt_nxt = good_pkt | (pkt_r & ~rd_clr); // [RQ12]
  assign value = {pkt_r, 1'b0, cnt_r}; // [RQ20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ext_page1_pkg::CNT_ZERO;
      pkt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pkt_r <= pkt_nxt;
    end
  end
endmodule

// >>> bench/ext_page1_chk.sv
/* port assertions for the page-one register bank.
   assumes one pclk domain and zero-wait apb. */
`timescale 1ns/10ps
module ext_page1_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [1:0] port_id, // port number
  input wire logic soft_reset, // soft reset
  input wire logic low_power_hold_input, // hold pin
  input wire logic main_wr, // main write
  input wire logic main_rd, // main read
  input wire logic [1:0] tx_remote_fault, // sent fault code
  input wire logic allow_1g_link, // gigabit allowed
  input wire logic spare_pin_nine_flf, // fast link failure
  input wire logic [1:0] xover_mode, // crossover
  input wire logic led_blink // blink
);
  logic page1_r;
  wire acc = psel && penable;
  wire lower = paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0;
  wire upper = paddr[31:7] == 25'h0 && paddr[6] && paddr[5:0] < 6'h3C;
  wire to_main = pwrite ? main_wr : main_rd;
  wire page_wr = acc && pwrite && paddr == 32'h0000007C;
  // shadow of the page register so routing can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) page1_r <= 1'b0;
    else if (page_wr) page1_r <= pwdata[15:0] == 16'h0001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_held;
    low_power_hold_input [*6];
  endsequence
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb answer wrong");
  property p_low; acc && lower |-> to_main; endproperty
  a_low: assert property (p_low) else $error("low address lost");
  property p_ext; acc && upper && page1_r |-> !main_wr && !main_rd; endproperty
  a_ext: assert property (p_ext) else $error("page one leaked");
  property p_main; acc && upper && !page1_r |-> to_main; endproperty
  a_main: assert property (p_main) else $error("main space missed");
  property p_hi; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper half set");
  property p_soft;
    soft_reset && !(acc && pwrite) |=>
      tx_remote_fault == 2'h0 && $stable(allow_1g_link);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");
  property p_flf;
    acc && pwrite && port_id != 2'h0 |=> $stable(spare_pin_nine_flf);
  endproperty
  a_flf: assert property (p_flf) else $error("flf from port");
  property p_xover; xover_mode != 2'h1; endproperty
  a_xover: assert property (p_xover) else $error("reserved xover");
  property p_blink; s_held |-> !led_blink; endproperty
  a_blink: assert property (p_blink) else $error("blink while held");
endmodule
bind ext_page1_regs ext_page1_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_id(port_id), .soft_reset(soft_reset), .main_wr(main_wr),
  .low_power_hold_input(low_power_hold_input), .main_rd(main_rd),
  .tx_remote_fault(tx_remote_fault), .allow_1g_link(allow_1g_link),
  .spare_pin_nine_flf(spare_pin_nine_flf), .xover_mode(xover_mode),
  .led_blink(led_blink));

// >>> bench/main_space_model.sv
/* main register space behind the bank.
   assumes strobes are one-cycle pulses on pclk. */
`timescale 1ns/10ps
module main_space_model (
  input wire logic pclk, // clock
  input wire logic main_wr, // write strobe
  input wire logic main_rd, // read strobe
  input wire logic [4:0] main_addr, // register address
  input wire logic [15:0] main_wdata, // write data
  output logic [15:0] main_rdata // read data
);
  logic [15:0] mem [0:31];
  logic [15:0] last_r = 16'h0000;
  initial for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
  always @(posedge pclk) begin
    if (main_wr) mem[main_addr] <= main_wdata;
    if (main_rd) last_r <= mem[main_addr];
  end
  // idle bus shows the inverse of the last word so a stale read fails
  assign main_rdata = main_rd ? mem[main_addr] : ~last_r;
endmodule

// >>> bench/extended_page1_regs_tb_top.sv
/* bench for the page-one bank: apb tasks and expected values.
   assumes zero-wait apb and the main space model. */
`timescale 1ns/10ps
module extended_page1_regs_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, soft_reset = 1'b0, far_end_fault = 1'b0;
  logic good_pkt = 1'b0, low_power_hold_input = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_q;
  logic [1:0] port_id = 2'h0, lp_remote_fault = 2'h0, tx_rf, xover;
  logic [15:0] m_rdata, m_wdata;
  logic [4:0] m_addr;
  logic m_wr, m_rd, a1g, a100, blink, flf, sdlow;
  logic [3:0] ledx;
  int failures = 0, tests_run = 0;
  ext_page1_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_id(port_id),
    .soft_reset(soft_reset), .lp_remote_fault(lp_remote_fault),
    .far_end_fault(far_end_fault), .good_pkt(good_pkt),
    .low_power_hold_input(low_power_hold_input), .main_rdata(m_rdata),
    .main_wr(m_wr), .main_rd(m_rd), .main_addr(m_addr),
    .main_wdata(m_wdata), .tx_remote_fault(tx_rf), .allow_1g_link(a1g),
    .allow_100_link(a100), .led_ext_mode(ledx), .led_blink(blink),
    .spare_pin_nine_flf(flf), .xover_mode(xover),
    .signal_detect_input_low(sdlow));
  main_space_model u_main (.pclk(pclk), .main_wr(m_wr), .main_rd(m_rd),
    .main_addr(m_addr), .main_wdata(m_wdata), .main_rdata(m_rdata));
  initial forever #5 pclk = ~pclk;
  // read data taken at the completing edge, before that edge's updates
  always @(posedge pclk) if (psel && penable && !pwrite) rd_q <= prdata;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  // sel 0 soft reset, 1 far-end fault, else good packet
  task automatic pulse(input int sel, input int n);
    case (sel)
      0: soft_reset <= 1'b1;
      1: far_end_fault <= 1'b1;
      default: good_pkt <= 1'b1;
    endcase
    repeat (n) @(posedge pclk);
    soft_reset <= 1'b0;
    far_end_fault <= 1'b0;
    good_pkt <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #600000;
    failures++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(32'h7C, 32'h0);
    xfer(1'b1, 32'h7C, 32'h1);
    lp_remote_fault <= 2'h2;
    rd(32'h40, 32'h2300);
    rd(32'h44, 32'h0);
    rd(32'h4C, 32'h0);
    xfer(1'b1, 32'h40, 32'hFFFF);
    rd(32'h40, 32'hE300);
    chk(32'({tx_rf, a1g, a100}), 32'hF);
    xfer(1'b1, 32'h40, 32'h0);
    rd(32'h40, 32'h2000);
    xfer(1'b1, 32'h40, 32'hC300);
    pulse(0, 1);
    rd(32'h40, 32'h2300);
    pulse(1, 1);
    rd(32'h40, 32'h2340);
    rd(32'h40, 32'h2300);
    pulse(2, 3);
    rd(32'h48, 32'h8003);
    rd(32'h48, 32'h0);
    pulse(2, 9999);
    rd(32'h48, 32'hA70F);
    pulse(2, 10000);
    rd(32'h48, 32'h8000);
    xfer(1'b1, 32'h4C, 32'hFFFF);
    rd(32'h4C, 32'hF81D);
    chk(32'({ledx, flf, xover, sdlow}), 32'hFF);
    port_id <= 2'h1;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 32'h4C, 32'(c * 4));
      // the stored field reads back as written; only the output remaps 01
      rd(32'h4C, 32'(c * 4 + 16));
      chk(32'(xover), 32'(c == 1 ? 0 : c));
    end
    port_id <= 2'h0;
    xfer(1'b1, 32'h4C, 32'h0800);
    low_power_hold_input <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(blink), 32'h0);
    low_power_hold_input <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(blink), 32'h1);
    // hold again: a running blink must stop
    low_power_hold_input <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(blink), 32'h0);
    xfer(1'b1, 32'h08, 32'h1234);
    rd(32'h08, 32'h1234);
    xfer(1'b1, 32'h7C, 32'h0);
    xfer(1'b1, 32'h40, 32'hABCD);
    rd(32'h40, 32'hABCD);
    rd(32'h08, 32'h1234);
    xfer(1'b1, 32'h7C, 32'h2);
    rd(32'h40, 32'hABCD);
    xfer(1'b1, 32'h7C, 32'h1);
    rd(32'h40, 32'h2300);
    rd(32'h80, 32'h0);
    close_out;
  end
endmodule
